//--- verilog/pwi_master.sv
// Host controller end: APB registers driving the two-wire link master
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`include "pwi_params.svh"
module pwi_master (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  pwi_if.master bus
);
  import pwi_pkg::*;

  logic sda_meta;
  logic sda_sync;
  logic tick;
  logic advance;
  logic mapped;
  logic [2:0] adv_seq;
  pwi_mst_state_t state, next_state;
  logic [1:0] phase, next_phase;
  logic [15:0] qtr_cnt, next_qtr_cnt;
  logic [15:0] clkdiv, next_clkdiv;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [2:0] seq, next_seq;
  logic [3:0] rd_left, next_rd_left, rd_count, next_rd_count;
  logic rd_mode, next_rd_mode;
  logic nack, next_nack;
  logic got_nack, next_got_nack;
  logic scl_oe, next_scl_oe;
  logic sda_oe, next_sda_oe;
  pwi_byte_t txsh, next_txsh;
  pwi_byte_t rxsh, next_rxsh;
  pwi_byte_t rxdata, next_rxdata;
  logic [15:0] txd, next_txd;
  logic [31:0] next_prdata;

  // Operation order; reads use a repeated START after the address
  function automatic pwi_mst_state_t seq_state(input logic [2:0] s,
                                               input logic rd);
    case (s)
      3'd0: seq_state = PWI_M_START;
      3'd1, 3'd2: seq_state = PWI_M_TX;
      3'd3: seq_state = rd ? PWI_M_START : PWI_M_TX;
      3'd4: seq_state = rd ? PWI_M_TX : PWI_M_STOP;
      3'd5: seq_state = rd ? PWI_M_RX : PWI_M_STOP;
      default: seq_state = PWI_M_STOP;
    endcase
  endfunction : seq_state

  function automatic pwi_byte_t tx_byte(input logic [2:0] s,
                                        input logic [15:0] t);
    case (s)
      3'd1: tx_byte = {`PWI_ID_CODE, 1'b0};
      3'd2: tx_byte = t[`PWI_TXD_ADDR_MSB:`PWI_TXD_ADDR_LSB];
      3'd3: tx_byte = t[`PWI_TXD_DATA_MSB:`PWI_TXD_DATA_LSB];
      3'd4: tx_byte = {`PWI_ID_CODE, 1'b1};
      default: tx_byte = 8'h00;
    endcase
  endfunction : tx_byte

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
    end
    else
    begin
      sda_meta <= bus.sda_i;
      sda_sync <= sda_meta;
    end
  end

  assign bus.m_scl_o = 1'b0;
  assign bus.m_sda_o = 1'b0;
  assign bus.m_scl_oe = scl_oe;
  assign bus.m_sda_oe = sda_oe;
  assign pready = 1'b1;
  assign mapped = (paddr == `PWI_REG_CMD) || (paddr == `PWI_REG_TXD)
               || (paddr == `PWI_REG_RXD) || (paddr == `PWI_REG_STAT)
               || (paddr == `PWI_REG_DIV);
  assign pslverr = psel && penable && !mapped;
  assign tick = ((qtr_cnt + 16'd1) >= clkdiv);
  assign adv_seq = seq + 3'd1;

  always_comb
  begin
    next_state = state;
    next_phase = phase;
    next_qtr_cnt = tick ? 16'h0000 : qtr_cnt + 16'd1;
    next_clkdiv = clkdiv;
    next_bit_cnt = bit_cnt;
    next_seq = seq;
    next_rd_left = rd_left;
    next_rd_count = rd_count;
    next_rd_mode = rd_mode;
    next_nack = nack;
    next_got_nack = got_nack;
    next_scl_oe = scl_oe;
    next_sda_oe = sda_oe;
    next_txsh = txsh;
    next_rxsh = rxsh;
    next_rxdata = rxdata;
    next_txd = txd;
    next_prdata = prdata;
    advance = 1'b0;
    // Read data is latched in the setup cycle, so it is a flop output
    if (psel && !penable)
    begin
      case (paddr)
        `PWI_REG_CMD: next_prdata = {24'h0, rd_count, 2'b00, rd_mode, 1'b0};
        `PWI_REG_TXD: next_prdata = {16'h0, txd};
        `PWI_REG_RXD: next_prdata = {24'h0, rxdata};
        `PWI_REG_STAT: next_prdata = {30'h0, nack, state != PWI_M_IDLE};
        `PWI_REG_DIV: next_prdata = {16'h0, clkdiv};
        default: next_prdata = 32'h0000_0000;
      endcase
    end
    if (psel && penable && pwrite)
    begin
      if (paddr == `PWI_REG_TXD)
      begin
        next_txd = pwdata[15:0];
      end
      if (paddr == `PWI_REG_DIV)
      begin
        next_clkdiv = pwdata[15:0];
      end
      // A go while busy is dropped; the link cannot be rearmed mid-frame
      if ((paddr == `PWI_REG_CMD) && (state == PWI_M_IDLE)
          && pwdata[`PWI_CMD_GO])
      begin
        next_rd_mode = pwdata[`PWI_CMD_READ];
        next_rd_count = pwdata[`PWI_CMD_CNT_MSB:`PWI_CMD_CNT_LSB];
        next_rd_left = pwdata[`PWI_CMD_CNT_MSB:`PWI_CMD_CNT_LSB];
        next_nack = 1'b0;
        next_seq = 3'd0;
        next_phase = 2'd0;
        next_qtr_cnt = 16'h0000;
        next_state = PWI_M_START;
      end
    end
    if (tick && (state != PWI_M_IDLE))
    begin
      next_phase = phase + 2'd1;
      case (state)
        PWI_M_START:
        begin
          // Data falls while clock high; also serves as repeated START
          case (phase)
            2'd0: next_sda_oe = 1'b0;
            2'd1: next_scl_oe = 1'b0;
            2'd2: next_sda_oe = 1'b1;
            default:
            begin
              next_scl_oe = 1'b1;
              advance = 1'b1;
            end
          endcase
        end
        PWI_M_TX, PWI_M_RX:
        begin
          case (phase)
            2'd0:
            begin
              // Data set only while the clock is low
              next_scl_oe = 1'b1;
              if (state == PWI_M_TX)
              begin
                next_sda_oe = (bit_cnt < 4'd8) && !txsh[7];
              end
              else
              begin
                // Acknowledge every byte but the last
                next_sda_oe = (bit_cnt == 4'd8) && (rd_left != 4'd0);
              end
            end
            2'd1: next_scl_oe = 1'b0;
            2'd2:
            begin
              if (bit_cnt == 4'd8)
              begin
                next_got_nack = sda_sync;
              end
              else
              begin
                next_rxsh = {rxsh[6:0], sda_sync};
              end
            end
            default:
            begin
              next_scl_oe = 1'b1;
              next_txsh = {txsh[6:0], 1'b0};
              next_bit_cnt = bit_cnt + 4'd1;
              if (bit_cnt == 4'd8)
              begin
                next_bit_cnt = 4'd0;
                if (state == PWI_M_RX)
                begin
                  next_rxdata = rxsh;
                  if (rd_left != 4'd0)
                  begin
                    next_rd_left = rd_left - 4'd1;
                  end
                  else
                  begin
                    advance = 1'b1;
                  end
                end
                else if (got_nack)
                begin
                  // Device refused: finish with a STOP
                  next_nack = 1'b1;
                  next_state = PWI_M_STOP;
                end
                else
                begin
                  advance = 1'b1;
                end
              end
            end
          endcase
        end
        PWI_M_STOP:
        begin
          case (phase)
            2'd0: next_sda_oe = 1'b1;
            2'd1: next_scl_oe = 1'b0;
            2'd2: next_sda_oe = 1'b0;
            default: next_state = PWI_M_IDLE;
          endcase
        end
        default: next_state = PWI_M_IDLE;
      endcase
      if (advance)
      begin
        next_seq = adv_seq;
        next_state = seq_state(adv_seq, rd_mode);
        next_txsh = tx_byte(adv_seq, txd);
        next_bit_cnt = 4'd0;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= PWI_M_IDLE;
      phase <= 2'd0;
      qtr_cnt <= 16'h0000;
      clkdiv <= `PWI_DIV_RESET;
      bit_cnt <= 4'd0;
      seq <= 3'd0;
      rd_left <= 4'd0;
      rd_count <= 4'd0;
      rd_mode <= 1'b0;
      nack <= 1'b0;
      got_nack <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      txsh <= 8'h00;
      rxsh <= 8'h00;
      rxdata <= 8'h00;
      txd <= 16'h0000;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      state <= next_state;
      phase <= next_phase;
      qtr_cnt <= next_qtr_cnt;
      clkdiv <= next_clkdiv;
      bit_cnt <= next_bit_cnt;
      seq <= next_seq;
      rd_left <= next_rd_left;
      rd_count <= next_rd_count;
      rd_mode <= next_rd_mode;
      nack <= next_nack;
      got_nack <= next_got_nack;
      scl_oe <= next_scl_oe;
      sda_oe <= next_sda_oe;
      txsh <= next_txsh;
      rxsh <= next_rxsh;
      rxdata <= next_rxdata;
      txd <= next_txd;
      prdata <= next_prdata;
    end
  end

endmodule : pwi_master

//--- verilog/pwi_params.svh
// Constants for the wiper potentiometer serial link and its host controller
`ifndef PWI_PARAMS_SVH
`define PWI_PARAMS_SVH

// Bus identifier of the device; value is arbitrary
`define PWI_ID_CODE 7'h2A
`define PWI_WIPER_ADDR 8'h00
`define PWI_WIPER_RESET 7'h40
`define PWI_POWERUP_CYCLES 8'h10

// Host controller register offsets
`define PWI_REG_CMD 8'h00
`define PWI_REG_TXD 8'h04
`define PWI_REG_RXD 8'h08
`define PWI_REG_STAT 8'h0C
`define PWI_REG_DIV 8'h10

// Command register fields
`define PWI_CMD_GO 0
`define PWI_CMD_READ 1
`define PWI_CMD_CNT_LSB 4
`define PWI_CMD_CNT_MSB 7
// Transmit register fields
`define PWI_TXD_DATA_LSB 0
`define PWI_TXD_DATA_MSB 7
`define PWI_TXD_ADDR_LSB 8
`define PWI_TXD_ADDR_MSB 15
// Status register fields
`define PWI_STAT_BUSY 0
`define PWI_STAT_NACK 1
// Quarter bit period in clk cycles
`define PWI_DIV_RESET 16'h0004

`endif

//--- verilog/pwi_pkg.sv
// Types shared by both ends of the wiper potentiometer link
package pwi_pkg;

  typedef logic [6:0] pwi_wiper_t;
  typedef logic [7:0] pwi_byte_t;

  typedef enum logic [8:0] {
    PWI_D_IDLE = 9'h001,
    PWI_D_ID = 9'h002,
    PWI_D_ID_ACK = 9'h004,
    PWI_D_ADDR = 9'h008,
    PWI_D_ADDR_ACK = 9'h010,
    PWI_D_WDATA = 9'h020,
    PWI_D_DATA_ACK = 9'h040,
    PWI_D_RDATA = 9'h080,
    PWI_D_RACK = 9'h100
  } pwi_dev_state_t;

  typedef enum logic [4:0] {
    PWI_M_IDLE = 5'h01,
    PWI_M_START = 5'h02,
    PWI_M_TX = 5'h04,
    PWI_M_RX = 5'h08,
    PWI_M_STOP = 5'h10
  } pwi_mst_state_t;

endpackage : pwi_pkg

//--- verilog/pwi_if.sv
// Open-drain two-wire link joining host controller and potentiometer
`timescale 1ns/1ps
interface pwi_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  logic scl_i;
  logic sda_i;

  // Pull-ups: a line is low only while an enabled driver pulls it low
  assign scl_i = !(m_scl_oe && !m_scl_o);
  assign sda_i = !((m_sda_oe && !m_sda_o) || (d_sda_oe && !d_sda_o));

  modport master (
    output m_scl_o,
    output m_scl_oe,
    output m_sda_o,
    output m_sda_oe,
    input scl_i,
    input sda_i
  );

  modport device (
    output d_sda_o,
    output d_sda_oe,
    input scl_i,
    input sda_i
  );
endinterface : pwi_if

//--- verilog/pwi_device.sv
// Serial slave end of the 128-tap volatile wiper potentiometer
`timescale 1ns/1ps
`include "pwi_params.svh"
module pwi_device #(
  parameter logic [7:0] POWERUP_CYCLES = `PWI_POWERUP_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  pwi_if.device bus,
  output pwi_pkg::pwi_wiper_t wiper_position,
  output logic powerup_done
);
  import pwi_pkg::*;

  logic scl_meta, scl_sync, scl_prev;
  logic sda_meta, sda_sync, sda_prev;
  logic scl_rise, scl_fall, start_seen, stop_seen;

  pwi_dev_state_t state, next_state;
  logic [3:0] bit_cnt, next_bit_cnt;
  pwi_byte_t shift, next_shift;
  logic addr_ok, next_addr_ok;
  logic rack_ok, next_rack_ok;
  pwi_wiper_t wiper, next_wiper;
  logic [7:0] pwr_cnt, next_pwr_cnt;

  // Both lines pass two flops; the third stage only serves edge finding
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      scl_prev <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
      sda_prev <= 1'b1;
    end
    else
    begin
      scl_meta <= bus.scl_i;
      scl_sync <= scl_meta;
      scl_prev <= scl_sync;
      sda_meta <= bus.sda_i;
      sda_sync <= sda_meta;
      sda_prev <= sda_sync;
    end
  end

  assign scl_rise = scl_sync && !scl_prev;
  assign scl_fall = !scl_sync && scl_prev;
  // Data edges while the clock stays high are bus conditions
  assign start_seen = scl_sync && scl_prev && sda_prev && !sda_sync;
  assign stop_seen = scl_sync && scl_prev && !sda_prev && sda_sync;

  assign powerup_done = (pwr_cnt == POWERUP_CYCLES);
  assign wiper_position = wiper;

  // Pull low during acknowledge slots and for zero read bits only;
  // the device never drives the clock
  assign bus.d_sda_o = 1'b0;
  assign bus.d_sda_oe = (state == PWI_D_ID_ACK)
                     || (state == PWI_D_ADDR_ACK)
                     || (state == PWI_D_DATA_ACK)
                     || ((state == PWI_D_RDATA) && !shift[7]);

  always_comb
  begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shift = shift;
    next_addr_ok = addr_ok;
    next_rack_ok = rack_ok;
    next_wiper = wiper;
    next_pwr_cnt = pwr_cnt;
    if (!powerup_done)
    begin
      next_pwr_cnt = pwr_cnt + 8'd1;
    end
    if (stop_seen)
    begin
      // A STOP anywhere ends the operation
      next_state = PWI_D_IDLE;
      next_addr_ok = 1'b0;
    end
    else if (start_seen && powerup_done)
    begin
      // Also taken mid-operation as a repeated START
      next_state = PWI_D_ID;
      next_bit_cnt = 4'd0;
    end
    else
    begin
      case (state)
        PWI_D_IDLE:
        begin
          next_bit_cnt = 4'd0;
        end
        PWI_D_ID, PWI_D_ADDR, PWI_D_WDATA:
        begin
          if (scl_rise)
          begin
            // Incoming bits enter at the bottom, MSB first
            next_shift = {shift[6:0], sda_sync};
            next_bit_cnt = bit_cnt + 4'd1;
          end
          else if (scl_fall && (bit_cnt == 4'd8))
          begin
            next_bit_cnt = 4'd0;
            if (state == PWI_D_ID)
            begin
              if (shift[7:1] != `PWI_ID_CODE)
              begin
                next_state = PWI_D_IDLE;
              end
              else if (!shift[0])
              begin
                next_state = PWI_D_ID_ACK;
                next_addr_ok = 1'b0;
              end
              else if (addr_ok)
              begin
                next_state = PWI_D_ID_ACK;
              end
              else
              begin
                // Read without a prior address: nothing to point at
                next_state = PWI_D_IDLE;
              end
            end
            else if (state == PWI_D_ADDR)
            begin
              if (shift == `PWI_WIPER_ADDR)
              begin
                next_state = PWI_D_ADDR_ACK;
                next_addr_ok = 1'b1;
              end
              else
              begin
                next_state = PWI_D_IDLE;
              end
            end
            else
            begin
              // Commit on the falling edge closing the last data bit,
              // only after a matched id and address
              if (addr_ok)
              begin
                next_wiper = shift[6:0];
                next_state = PWI_D_DATA_ACK;
              end
              else
              begin
                next_state = PWI_D_IDLE;
              end
              next_addr_ok = 1'b0;
            end
          end
        end
        PWI_D_ID_ACK:
        begin
          if (scl_fall)
          begin
            next_bit_cnt = 4'd0;
            if (shift[0])
            begin
              // First read bit goes out as soon as the clock is low
              next_shift = {1'b0, wiper};
              next_state = PWI_D_RDATA;
            end
            else
            begin
              next_state = PWI_D_ADDR;
            end
          end
        end
        PWI_D_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            next_state = PWI_D_WDATA;
          end
        end
        PWI_D_DATA_ACK:
        begin
          if (scl_fall)
          begin
            next_state = PWI_D_IDLE;
          end
        end
        PWI_D_RDATA:
        begin
          if (scl_fall)
          begin
            if (bit_cnt == 4'd7)
            begin
              // Release for the master's acknowledge slot
              next_state = PWI_D_RACK;
              next_rack_ok = 1'b0;
            end
            else
            begin
              next_shift = {shift[6:0], 1'b0};
              next_bit_cnt = bit_cnt + 4'd1;
            end
          end
        end
        PWI_D_RACK:
        begin
          if (scl_rise)
          begin
            next_rack_ok = !sda_sync;
          end
          else if (scl_fall)
          begin
            next_bit_cnt = 4'd0;
            if (rack_ok)
            begin
              next_shift = {1'b0, wiper};
              next_state = PWI_D_RDATA;
            end
            else
            begin
              next_state = PWI_D_IDLE;
            end
          end
        end
        default:
        begin
          next_state = PWI_D_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= PWI_D_IDLE;
      bit_cnt <= 4'd0;
      shift <= 8'h00;
      addr_ok <= 1'b0;
      rack_ok <= 1'b0;
      wiper <= `PWI_WIPER_RESET;
      pwr_cnt <= 8'h00;
    end
    else
    begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shift <= next_shift;
      addr_ok <= next_addr_ok;
      rack_ok <= next_rack_ok;
      wiper <= next_wiper;
      pwr_cnt <= next_pwr_cnt;
    end
  end

endmodule : pwi_device

//--- testbench/pwi_link_assertions.sv
// Concurrent checks on the link between host controller and potentiometer
`timescale 1ns/1ps
`include "pwi_params.svh"
module pwi_link_assertions #(
  parameter logic [7:0] POWERUP_CYCLES = `PWI_POWERUP_CYCLES
) (
  input logic clk,
  input logic reset_n,
  input logic scl_i,
  input logic sda_i,
  input logic d_sda_oe,
  input pwi_pkg::pwi_wiper_t wiper_position,
  input logic powerup_done
);
  import pwi_pkg::*;
  logic prev_scl, prev_sda, busy, next_busy;
  logic [7:0] cnt, next_cnt;

  // Frame tracker: open from START to STOP, seen on the resolved wires
  always_comb
  begin
    next_busy = busy;
    if (scl_i && prev_scl && prev_sda && !sda_i)
      next_busy = 1'b1;
    else if (scl_i && prev_scl && !prev_sda && sda_i)
      next_busy = 1'b0;
    next_cnt = (cnt == 8'hFF) ? cnt : cnt + 8'h01;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prev_scl <= 1'b1;
      prev_sda <= 1'b1;
      busy <= 1'b0;
      cnt <= 8'h00;
    end
    else
    begin
      prev_scl <= scl_i;
      prev_sda <= sda_i;
      busy <= next_busy;
      cnt <= next_cnt;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  property p_rel_reset;
    $rose(reset_n) |-> !d_sda_oe && wiper_position == `PWI_WIPER_RESET;
  endproperty
  a_rel_reset: assert property (p_rel_reset)
    else $error("wiper or data line wrong after reset");
  property p_quiet_powerup;
    d_sda_oe |-> powerup_done;
  endproperty
  a_quiet_powerup: assert property (p_quiet_powerup)
    else $error("device drove data before power-up ended");
  // Loose by two cycles: the exact compare point is the designer's choice
  property p_pu_early;
    powerup_done |-> int'(cnt) + 2 >= int'(POWERUP_CYCLES);
  endproperty
  a_pu_early: assert property (p_pu_early)
    else $error("power-up ended too early");
  property p_pu_late;
    !powerup_done |-> int'(cnt) <= int'(POWERUP_CYCLES) + 2;
  endproperty
  a_pu_late: assert property (p_pu_late)
    else $error("power-up ended too late");
  property p_sda_scl_low;
    $changed(d_sda_oe) |-> !scl_i && !$past(scl_i);
  endproperty
  a_sda_scl_low: assert property (p_sda_scl_low)
    else $error("device changed data while clock high");
  property p_wiper_frame;
    $changed(wiper_position) |-> busy && !scl_i;
  endproperty
  a_wiper_frame: assert property (p_wiper_frame)
    else $error("wiper changed outside a write data fall");
  property p_dev_in_frame;
    d_sda_oe |-> busy;
  endproperty
  a_dev_in_frame: assert property (p_dev_in_frame)
    else $error("device drove data outside a frame");
  property p_scl_high;
    $rose(scl_i) |-> scl_i [*4];
  endproperty
  a_scl_high: assert property (p_scl_high)
    else $error("clock high phase too short");
endmodule : pwi_link_assertions

//--- testbench/tb_top.sv
// Self-checking bench: host controller and potentiometer on one link
`timescale 1ns/1ps
`include "pwi_params.svh"
module tb_top;
  import pwi_pkg::*;
  localparam logic [7:0] PU = 8'h40;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, powerup_done;
  pwi_wiper_t wiper_position;
  pwi_wiper_t wexp = `PWI_WIPER_RESET;
  logic [7:0] corner [3] = '{8'h00, 8'h7F, 8'hFF};
  int miscompares = 0;
  int compares = 0;
  logic [7:0] wv;
  logic frame_open;

  // Open from START to STOP as seen by the link checker
  assign frame_open = pwi_link_assertions_inst.busy;

  always #10 clk = ~clk;

  pwi_if link();
  pwi_master pwi_master_inst (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(link));
  pwi_device #(.POWERUP_CYCLES(PU)) pwi_device_inst (.clk(clk),
    .reset_n(reset_n), .bus(link), .wiper_position(wiper_position),
    .powerup_done(powerup_done));
  pwi_link_assertions #(.POWERUP_CYCLES(PU)) pwi_link_assertions_inst (
    .clk(clk), .reset_n(reset_n), .scl_i(link.scl_i), .sda_i(link.sda_i),
    .d_sda_oe(link.d_sda_oe), .wiper_position(wiper_position),
    .powerup_done(powerup_done));

  task automatic print_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict

  task automatic chk_word(input string n, input logic [31:0] e,
                          input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk_word

  task automatic chk_wiper(input string n, input pwi_wiper_t e);
    compares++;
    if (wiper_position !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, wiper_position);
    end
  endtask : chk_wiper

  // Holds the request until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // No wait-state count is assumed; only the watchdog ends a hang
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Leaves the final status word in rd
  task automatic xfer(input logic r, input logic [7:0] a,
                      input logic [7:0] v, input logic [3:0] x);
    apb(1'b1, `PWI_REG_TXD, {16'h0, a, v});
    apb(1'b1, `PWI_REG_CMD, {24'h0, x, 2'b00, r, 1'b1});
    do
    begin
      apb(1'b0, `PWI_REG_STAT, 32'h0);
    end
    while (rd[0] !== 1'b0);
  endtask : xfer

  task automatic wr_check(input logic [7:0] a, input logic [7:0] v,
                          input logic [3:0] x);
    xfer(1'b0, a, v, 4'h0);
    chk_word("write nack", {31'h0, a != 8'h00}, {31'h0, rd[1]});
    if (a == 8'h00)
      wexp = v[6:0];
    chk_wiper("wiper", wexp);
    xfer(1'b1, a, 8'h00, x);
    chk_word("read nack", {31'h0, a != 8'h00}, {31'h0, rd[1]});
    chk_word("frame open", 32'h0, {31'h0, frame_open});
    apb(1'b0, `PWI_REG_RXD, 32'h0);
    if (a == 8'h00)
      chk_word("read data", {25'h0, wexp}, rd);
    $display("test access %h %h done", a, v);
  endtask : wr_check

  initial
  begin
    repeat (60000) @(posedge clk);
    miscompares++;
    $display("watchdog expired");
    print_verdict();
  end

  initial
  begin
    void'($urandom(32'hF2163D71));
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    // Sent while the device is still powering up, so it must go unanswered
    xfer(1'b1, 8'h00, 8'h00, 4'h0);
    chk_word("early nack", 32'h1, {31'h0, rd[1]});
    chk_wiper("reset wiper", `PWI_WIPER_RESET);
    apb(1'b0, `PWI_REG_DIV, 32'h0);
    chk_word("div", {16'h0, `PWI_DIV_RESET}, rd);
    apb(1'b0, 8'h14, 32'h0);
    chk_word("unmapped err", 32'h1, {31'h0, err});
    chk_word("unmapped data", 32'h0, rd);
    $display("test reset done");
    repeat (80) @(posedge clk);
    wr_check(8'h01, 8'h2C, 4'h1);
    for (int i = 0; i < 8; i++)
    begin
      wv = (i < 3) ? corner[i] : 8'($urandom);
      wr_check(8'h00, wv, 4'(i % 4));
    end
    wr_check(8'($urandom_range(255, 1)), 8'($urandom), 4'h0);
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    wexp = `PWI_WIPER_RESET;
    @(posedge clk);
    chk_wiper("second reset wiper", wexp);
    $display("test second reset done");
    print_verdict();
  end
endmodule : tb_top
